// *** bench/hbs_midpoint_model.sv ***
// midpoint sensing model: slope flag after both switches drop
// assumes gates from the sequencer; mode 0 prompt, 1 slow, 2 capacitive
`timescale 1ns/10ps
module hbs_midpoint_model (
  input  wire logic       core_clk,
  input  wire logic       arm,
  input  wire logic       high_side_gate,
  input  wire logic       low_side_gate,
  input  wire logic [1:0] mode,
  output logic            slope_active
);
  logic [9:0] cnt;
  // cycles since both switches went off; saturates so a stalled bridge stays quiet
  always_ff @(posedge core_clk) begin
    if (!arm || high_side_gate || low_side_gate) cnt <= 10'h000;
    else if (cnt != 10'h3ff) cnt <= cnt + 10'h001;
  end
  // short swing, swing past the charge time, or none at all in capacitive mode
  assign slope_active = (mode != 2'h2) && (cnt >= 10'h002)
                        && (cnt < ((mode == 2'h1) ? 10'h192 : 10'h005));
endmodule

// *** bench/hbs_sequencer_bench.sv ***
// self-checking bench for the switch sequencer with a midpoint model
// assumes the checker is bound to the sequencer by its own file
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module hbs_sequencer_bench;
  import hbs_pkg::*;
  logic        core_clk, rst_b, boost_above_uvp, boost_above_restart;
  logic        protect_ok, softstart_enable_input;
  logic [15:0] osc_step;
  logic [1:0]  mode;
  logic        slope_active, high_side_gate, low_side_gate, cap_mode, boost_uvp, forced_on;
  logic [15:0] oscillator_cap_node, adaptive_dead_time;
  hbs_state_t  seq_state;
  int          errors, checks, cyc, n, rises;
  hbs_sequencer hbs_sequencer_inst (.core_clk(core_clk), .rst_b(rst_b), .osc_step(osc_step),
    .boost_above_uvp(boost_above_uvp), .boost_above_restart(boost_above_restart),
    .protect_ok(protect_ok), .softstart_enable_input(softstart_enable_input),
    .slope_active(slope_active), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .oscillator_cap_node(oscillator_cap_node),
    .cap_mode(cap_mode), .boost_uvp(boost_uvp), .forced_on(forced_on),
    .adaptive_dead_time(adaptive_dead_time), .seq_state(seq_state));
  hbs_midpoint_model hbs_midpoint_model_inst (.core_clk(core_clk),
    .arm(softstart_enable_input), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .mode(mode), .slope_active(slope_active));
  // bounded wait for one gate high, sampled at falling edges
  task automatic wait_on(input bit hs);
    n = 0;
    do begin @(negedge core_clk); n++; end
    while (((hs ? high_side_gate : low_side_gate) !== 1'b1) && n < 3000);
  endtask : wait_on
  task automatic t_start;
    @(posedge core_clk);
    boost_above_restart <= 1'b1;
    boost_above_uvp <= 1'b1;
    softstart_enable_input <= 1'b1;
    repeat (10) @(negedge core_clk);
    `CHK(seq_state, HBS_STOP)
    @(posedge core_clk);
    protect_ok <= 1'b1;
    wait_on(0);
    `CHK(high_side_gate, 1'b0)
    wait_on(1);
    `CHK(low_side_gate, 1'b0)
    `CHK(adaptive_dead_time >= 16'h0005, 1'b1)
  endtask : t_start
  task automatic t_slow;
    @(posedge core_clk);
    mode <= 2'h1;
    wait_on(0);
    `CHK(forced_on, 1'b1)
  endtask : t_slow
  task automatic t_cap;
    @(posedge core_clk);
    mode <= 2'h2;
    wait_on(1);
    `CHK(forced_on, 1'b1)
    `CHK(oscillator_cap_node, 16'hf000)
    `CHK(cap_mode, 1'b1)
    `CHK(n > 300, 1'b1)
    @(posedge core_clk);
    mode <= 2'h0;
    wait_on(0);
    `CHK(forced_on, 1'b0)
  endtask : t_cap
  task automatic t_uvp;
    logic prev;
    @(posedge core_clk);
    boost_above_uvp <= 1'b0;
    boost_above_restart <= 1'b0;
    rises = 0;
    prev = 1'b1;
    // low side is already on here, so only a fresh rise counts
    repeat (800) begin
      @(negedge core_clk);
      if (low_side_gate && !prev) rises++;
      prev = low_side_gate;
    end
    `CHK(rises, 0)
    `CHK(seq_state, HBS_STOP)
    @(posedge core_clk);
    boost_above_uvp <= 1'b1;
    repeat (50) @(negedge core_clk);
    `CHK(boost_uvp, 1'b1)
    @(posedge core_clk);
    boost_above_restart <= 1'b1;
    wait_on(0);
    `CHK(low_side_gate, 1'b1)
  endtask : t_uvp
  task automatic t_disable;
    @(posedge core_clk);
    protect_ok <= 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(low_side_gate | high_side_gate, 1'b0)
  endtask : t_disable
  task final_report;
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // free-running clock at 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // cut a hang short well beyond the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    {rst_b, boost_above_uvp, boost_above_restart, protect_ok, softstart_enable_input} = '0;
    osc_step = 16'h0400;
    mode = 2'h0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    `CHK(boost_uvp, 1'b1)
    t_start;
    t_slow;
    t_cap;
    t_uvp;
    t_disable;
    final_report;
  end
endmodule : hbs_sequencer_bench

// *** bench/hbs_sequencer_sva.sv ***
// checker for the switch sequencer: gate order, dead time, start and stop
// assumes it sees only the sequencer ports and is bound below
`timescale 1ns/10ps
module hbs_sequencer_sva
  import hbs_pkg::*;
#(
  parameter int W      = 16,
  parameter int NO_MIN = 5
) (
  input wire logic         core_clk,
  input wire logic         rst_b,
  input wire logic [W-1:0] osc_step,
  input wire logic         boost_above_uvp,
  input wire logic         boost_above_restart,
  input wire logic         protect_ok,
  input wire logic         softstart_enable_input,
  input wire logic         slope_active,
  input wire logic         high_side_gate,
  input wire logic         low_side_gate,
  input wire logic [W-1:0] oscillator_cap_node,
  input wire logic         cap_mode,
  input wire logic         boost_uvp,
  input wire logic         forced_on,
  input wire logic [15:0]  adaptive_dead_time,
  input wire hbs_state_t   seq_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] dcnt;
  logic        seen;
  logic        last_ls;
  logic        hs_q;
  logic        ls_q;
  logic        gate_up;
  // gate levels one cycle back, so a rise is seen without a sampled-value call in a net
  always_ff @(posedge core_clk) begin
    hs_q <= high_side_gate;
    ls_q <= low_side_gate;
  end
  assign gate_up = (high_side_gate && !hs_q) || (low_side_gate && !ls_q);
  // dead-time length and slope seen, cleared outside dead so each gap stands alone
  always_ff @(posedge core_clk) begin
    dcnt <= (seq_state == HBS_DEAD) ? dcnt + 16'h0001 : 16'h0000;
    seen <= (seq_state == HBS_DEAD) && (seen || slope_active);
  end
  // side that conducted last; a stop forgets it since restart begins low side
  always_ff @(posedge core_clk) begin
    if (seq_state == HBS_STOP) last_ls <= 1'b0;
    else if (low_side_gate) last_ls <= 1'b1;
    else if (high_side_gate) last_ls <= 1'b0;
  end
  a_no_overlap: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates high");
  a_on_from_dead: assert property (gate_up |-> $past(seq_state) == HBS_DEAD)
    else $error("gate on outside dead time");
  a_min_dead: assert property (gate_up |-> $past(dcnt) >= NO_MIN)
    else $error("dead time too short");
  a_hs_after_ls: assert property ($rose(high_side_gate) |-> last_ls)
    else $error("high side twice");
  a_slope_end: assert property (gate_up && !forced_on |-> $past(seen) && !$past(slope_active))
    else $error("gate on without slope end");
  a_forced_pulse: assert property (forced_on |-> gate_up)
    else $error("forced flag without turn on");
  a_stop_disable: assert property (!(protect_ok && softstart_enable_input) |=> !high_side_gate && !low_side_gate)
    else $error("gate on while disabled");
  a_start_ok: assert property ($past(seq_state) == HBS_STOP && seq_state == HBS_DEAD
    |-> $past(protect_ok && softstart_enable_input && !boost_uvp))
    else $error("start without permission");
  a_uvp_block: assert property ($rose(low_side_gate) |-> !$past(boost_uvp))
    else $error("low side on in undervoltage");
  a_uvp_restart: assert property (boost_uvp && boost_above_restart && boost_above_uvp |=> !boost_uvp)
    else $error("undervoltage not cleared");
endmodule : hbs_sequencer_sva

bind hbs_sequencer hbs_sequencer_sva #(.W(W), .NO_MIN(NO_MIN)) hbs_sequencer_sva_inst (
  .core_clk(core_clk), .rst_b(rst_b), .osc_step(osc_step), .boost_above_uvp(boost_above_uvp),
  .boost_above_restart(boost_above_restart), .protect_ok(protect_ok),
  .softstart_enable_input(softstart_enable_input), .slope_active(slope_active),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .oscillator_cap_node(oscillator_cap_node), .cap_mode(cap_mode), .boost_uvp(boost_uvp),
  .forced_on(forced_on), .adaptive_dead_time(adaptive_dead_time), .seq_state(seq_state));

// *** src/hbs_consts.svh ***
// timing, level and reset constants for the half-bridge switch sequencer
// assumes a single 25 MHz core clock and comparator flags already in that domain
//
// Overview of operation
// - boost undervoltage stops switching at low-side turn-on
// - restart at higher boost level, giving hysteresis
// - divide-by-two alternates high and low side
// - oscillator bottom ends each conduction interval
// - switch-on taken from adaptive non-overlap sensing
// - start only with protections ok and enabled
// - turn on opposite switch after slope starts, ends
// - minimum non-overlap time before any switch-on
// - slope past charge time forces switch-on
// - capacitive mode waits for slope to start
// - oscillator slowed while waiting for slope start
// - reduced charge rate until slope start detected
// - oscillator upper level forces switch-on without slope
// - capacitive mode raises switching frequency
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH

`define HBS_CLK_PERIOD_NS 40
`define HBS_T_NO_MIN_NS   200
`define HBS_NO_MIN_CYC    ((`HBS_T_NO_MIN_NS + `HBS_CLK_PERIOD_NS - 1) / `HBS_CLK_PERIOD_NS)

`define HBS_OSC_W         16
`define HBS_OSC_UPPER     16'hf000
`define HBS_OSC_LOWER     16'h0000
`define HBS_OSC_RED_DIV   8
`define HBS_CAP_BOOST     16'h0040

`define HBS_DEAD_RST      16'h0000

`endif

// *** src/hbs_oscillator.sv ***
// digital triangle oscillator: ramps up (charge) then down (discharge)
// assumes step is held stable by the sequencer and run drops to restart it
`timescale 1ns/10ps
`include "hbs_consts.svh"
module hbs_oscillator #(
  parameter int W       = `HBS_OSC_W,
  parameter int RED_DIV = `HBS_OSC_RED_DIV
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         run,
  input  wire logic [W-1:0] step,
  input  wire logic         reduced,
  output logic      [W-1:0] level,
  output logic              charging,
  output logic              at_upper,
  output logic              at_lower
);
  import hbs_pkg::*;

  localparam logic [W-1:0] UPPER = W'(`HBS_OSC_UPPER);
  localparam logic [W-1:0] LOWER = W'(`HBS_OSC_LOWER);

  if (RED_DIV < 2 || RED_DIV > 255) begin : g_chk
    $error("hbs_oscillator: RED_DIV out of range");
  end

  logic [7:0] red_cnt;
  logic       red_tick;
  logic [W:0] up_sum;
  logic [W:0] dn_dif;

  // divider for the reduced charge rate, a one-cycle enable pulse
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run || red_tick) begin
      red_cnt <= 8'h00;
    end else begin
      red_cnt <= red_cnt + 8'h01;
    end
  end
  assign red_tick = (red_cnt == 8'(RED_DIV - 1));

  assign up_sum = {1'b0, level} + {1'b0, step};
  assign dn_dif = {1'b0, level} - {1'b0, step};

  // ramp; the charge half only advances on the divider tick when reduced
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run) begin
      level    <= LOWER;
      charging <= 1'b1;
      at_upper <= 1'b0;
      at_lower <= 1'b0;
    end else begin
      at_upper <= 1'b0;
      at_lower <= 1'b0;
      if (charging) begin
        if (!reduced || red_tick) begin
          if (up_sum >= {1'b0, UPPER}) begin
            level    <= UPPER;
            charging <= 1'b0;
            at_upper <= 1'b1;
          end else begin
            level <= up_sum[W-1:0];
          end
        end
      end else if (dn_dif[W] || dn_dif[W-1:0] <= LOWER) begin
        level    <= LOWER;
        charging <= 1'b1;
        at_lower <= 1'b1;
      end else begin
        level <= dn_dif[W-1:0];
      end
    end
  end

endmodule : hbs_oscillator

// *** src/hbs_pkg.sv ***
// types shared by the half-bridge switch sequencer files
// assumes hbs_consts.svh supplies the numeric constants
package hbs_pkg;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    HBS_STOP  = 4'b0001,
    HBS_DEAD  = 4'b0010,
    HBS_HS_ON = 4'b0100,
    HBS_LS_ON = 4'b1000
  } hbs_state_t;

endpackage : hbs_pkg

// *** src/hbs_sequencer.sv ***
// half-bridge switch sequencer: gate commands from oscillator and slope sense
// assumes all sense flags are comparator outputs synchronous to core_clk
// assumes slope_active is high while the midpoint is rising or falling
`timescale 1ns/10ps
`include "hbs_consts.svh"
module hbs_sequencer #(
  parameter int W       = `HBS_OSC_W,
  parameter int NO_MIN  = `HBS_NO_MIN_CYC,
  parameter int RED_DIV = `HBS_OSC_RED_DIV
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] osc_step,
  input  wire logic         boost_above_uvp,
  input  wire logic         boost_above_restart,
  input  wire logic         protect_ok,
  input  wire logic         softstart_enable_input,
  input  wire logic         slope_active,
  output logic              high_side_gate,
  output logic              low_side_gate,
  output logic      [W-1:0] oscillator_cap_node,
  output logic              cap_mode,
  output logic              boost_uvp,
  output logic              forced_on,
  output logic      [15:0]  adaptive_dead_time,
  output hbs_pkg::hbs_state_t seq_state
);
  import hbs_pkg::*;

  if (NO_MIN < 1 || NO_MIN > 65535) begin : g_chk_nomin
    $error("hbs_sequencer: NO_MIN out of range");
  end
  if (W < 16) begin : g_chk_w
    $error("hbs_sequencer: W too small");
  end

  hbs_state_t next_state;

  logic         next_is_hs;
  logic         slope_seen;
  logic         force_pend;
  logic [15:0]  dead_cnt;
  logic         min_done;
  logic         slope_end;
  logic         switch_on;
  logic         start_ok;
  logic         osc_run;
  logic         osc_reduced;
  logic         osc_charging;
  logic         osc_upper;
  logic         osc_lower;
  logic [W-1:0] eff_step;
  logic [W:0]   boost_sum;
  logic [W-1:0] osc_level;

  // start permission: protections, enable level and boost hysteresis
  assign start_ok = protect_ok && softstart_enable_input && !boost_uvp;

  // the slope has started and then finished since turn-off
  assign slope_end = slope_seen && !slope_active;

  // minimum non-overlap counted from the switch-off instant
  assign min_done = (dead_cnt >= 16'(NO_MIN));

  // switch-on decision: adaptive end of slope, or the charge-time limit;
  // without a started slope only the upper level may force it on
  assign switch_on = min_done && (slope_end || force_pend || osc_upper);

  // oscillator runs whenever the bridge is switching
  assign osc_run = (seq_state != HBS_STOP);

  // slow the charge ramp while the midpoint has not yet begun to move
  assign osc_reduced = (seq_state == HBS_DEAD) && !slope_seen && !slope_active;

  // capacitive mode pushes the frequency up; saturates rather than wraps
  assign boost_sum = {1'b0, osc_step} + {1'b0, W'(`HBS_CAP_BOOST)};
  always_comb begin
    eff_step = osc_step;
    if (cap_mode) begin
      eff_step = boost_sum[W] ? {W{1'b1}} : boost_sum[W-1:0];
    end
  end

  hbs_oscillator #(
    .W       (W),
    .RED_DIV (RED_DIV)
  ) u_osc (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (osc_run),
    .step     (eff_step),
    .reduced  (osc_reduced),
    .level    (osc_level),
    .charging (osc_charging),
    .at_upper (osc_upper),
    .at_lower (osc_lower)
  );

  // next-state logic; states are exclusive so gates can never overlap
  always_comb begin
    next_state = seq_state;
    unique case (seq_state)
      HBS_STOP: begin
        if (start_ok) begin
          next_state = HBS_DEAD;
        end
      end
      HBS_DEAD: begin
        if (!protect_ok || !softstart_enable_input) begin
          next_state = HBS_STOP;
        end else if (switch_on) begin
          if (!next_is_hs && boost_uvp) begin
            next_state = HBS_STOP;
          end else if (next_is_hs) begin
            next_state = HBS_HS_ON;
          end else begin
            next_state = HBS_LS_ON;
          end
        end
      end
      HBS_HS_ON, HBS_LS_ON: begin
        if (!protect_ok || !softstart_enable_input) begin
          next_state = HBS_STOP;
        end else if (osc_lower) begin
          next_state = HBS_DEAD;
        end
      end
      default: begin
        next_state = HBS_STOP;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      seq_state <= HBS_STOP;
    end else begin
      seq_state <= next_state;
    end
  end

  // gate commands come straight from the next state, one flop each
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
    end else begin
      high_side_gate <= (next_state == HBS_HS_ON);
      low_side_gate  <= (next_state == HBS_LS_ON);
    end
  end

  // divide-by-two: the side to turn on flips at every switch-on
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      next_is_hs <= 1'b0;
    end else if (seq_state == HBS_STOP) begin
      next_is_hs <= 1'b0; // low side first so the bootstrap charges
    end else if (seq_state == HBS_DEAD && next_state != HBS_DEAD) begin
      next_is_hs <= !next_is_hs;
    end
  end

  // slope tracking inside the non-overlap window
  always_ff @(posedge core_clk) begin
    if (!rst_b || seq_state != HBS_DEAD) begin
      slope_seen <= 1'b0;
    end else if (slope_active) begin
      slope_seen <= 1'b1;
    end
  end

  // upper level seen before the minimum ran out: hold the force request
  always_ff @(posedge core_clk) begin
    if (!rst_b || seq_state != HBS_DEAD) begin
      force_pend <= 1'b0;
    end else if (osc_upper) begin
      force_pend <= 1'b1;
    end
  end

  // non-overlap counter, saturating, restarted at every switch-off
  always_ff @(posedge core_clk) begin
    if (!rst_b || seq_state != HBS_DEAD) begin
      dead_cnt <= `HBS_DEAD_RST;
    end else if (dead_cnt != 16'hffff) begin
      dead_cnt <= dead_cnt + 16'h0001;
    end
  end

  // last measured non-overlap time, in core clock cycles
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adaptive_dead_time <= `HBS_DEAD_RST;
    end else if (seq_state == HBS_DEAD && next_state != HBS_DEAD) begin
      adaptive_dead_time <= dead_cnt + 16'h0001;
    end
  end

  // forced switch-on marker: one cycle, aligned with the gate edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      forced_on <= 1'b0;
    end else begin
      forced_on <= (seq_state == HBS_DEAD) && (next_state == HBS_HS_ON ||
                   next_state == HBS_LS_ON) && !slope_end;
    end
  end

  // boost undervoltage with hysteresis; a trip in the release cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      boost_uvp <= 1'b1;
    end else if (!boost_above_uvp) begin
      boost_uvp <= 1'b1;
    end else if (boost_above_restart) begin
      boost_uvp <= 1'b0;
    end
  end

  // capacitive mode: upper level reached with no slope; cleared by a
  // normal slope end; detection wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b || seq_state == HBS_STOP) begin
      cap_mode <= 1'b0;
    end else if (seq_state == HBS_DEAD && osc_upper && !slope_seen && !slope_active) begin
      cap_mode <= 1'b1;
    end else if (seq_state == HBS_DEAD && slope_end) begin
      cap_mode <= 1'b0;
    end
  end

  // oscillator level mirror for observation
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      oscillator_cap_node <= W'(`HBS_OSC_LOWER);
    end else begin
      oscillator_cap_node <= osc_level;
    end
  end

endmodule : hbs_sequencer
